// *** sei_regs.vh ***
/*
 * Constants for the SPI status, error and request block: flag bit
 * positions, reset values and clear masks.
 * Assumes inclusion by its bare name from the sei_* design files.
 */
`ifndef SEI_REGS_VH
`define SEI_REGS_VH

// ----------------------------------------------------------------
// Status flag positions (status_flag_register layout)
// ----------------------------------------------------------------
`define SEI_FLAG_W      8
`define SEI_TXE         0
`define SEI_RX_NOT_EMPTY_FLAG        1
`define SEI_SSF         2
`define SEI_SSR         3
`define SEI_UD          4
`define SEI_OV          5
`define SEI_SLAVE_SELECT_ERROR_FLAG       6
`define SEI_MODE_FAULT_FLAG        7

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define SEI_FLAGS_RST   8'h01
`define SEI_CLR_MASK    8'hFE
`define SEI_SYNC_RST    1'b1

`endif

// *** sei_pin_sync.v ***
/*
 * Three-flop synchroniser for pins from outside the clock domain.
 * A new level is passed on once the second and third flops agree.
 * Assumes clk and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "sei_regs.vh"

module sei_pin_sync #(
    parameter WIDTH = 3
) (
    input  wire             clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] pinLvl
);

    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    reg [WIDTH-1:0] lvl_reg;
    genvar i;

    // ----------------------------------------------------------------
    // Flop chain; first stage feeds only the second
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            s1_reg <= {WIDTH{`SEI_SYNC_RST}};
            s2_reg <= {WIDTH{`SEI_SYNC_RST}};
            s3_reg <= {WIDTH{`SEI_SYNC_RST}};
        end else begin
            s1_reg <= pinIn;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Per-bit agreement filter, a glitch of one cycle never passes
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gAgree
            always @(posedge clk) begin
                if (sys_rst) begin
                    lvl_reg[i] <= `SEI_SYNC_RST;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    lvl_reg[i] <= s3_reg[i];
                end
            end
        end
    endgenerate

    assign pinLvl = lvl_reg;

endmodule // sei_pin_sync

// *** sei_req_gen.v ***
/*
 * Interrupt and DMA request generation from the status flags.
 * Assumes flags come from registers in the same clock domain.
 */
`timescale 1ns/1ps
`include "sei_regs.vh"

module sei_req_gen (
    input  wire [`SEI_FLAG_W-1:0] flags,
    input  wire [`SEI_FLAG_W-1:0] irqEnable,
    input  wire                   txDmaEnable,
    input  wire                   rxDmaEnable,
    output wire                   irqRequest,
    output wire                   txDmaRequest,
    output wire                   rxDmaRequest
);

    // ----------------------------------------------------------------
    // One shared level request, held while any enabled flag is set
    // ----------------------------------------------------------------
    assign irqRequest   = |(flags & irqEnable);

    // Two independent DMA requests, each behind its own enable
    assign txDmaRequest = txDmaEnable & flags[`SEI_TXE];
    assign rxDmaRequest = rxDmaEnable & flags[`SEI_RX_NOT_EMPTY_FLAG];

endmodule // sei_req_gen

// *** sei_flag_core.v ***
/*
 * SPI status, error, interrupt and DMA request logic with a minimal
 * slave frame tracker (MSB first, sample on the leading clock edge).
 * Assumes the master shift engine sits outside and reports frame
 * start/done with received data; the link clock and select are pins.
 */
`timescale 1ns/1ps
`include "sei_regs.vh"

module sei_flag_core #(
    parameter FRAME_W = 8
) (
    input  wire                   clk,
    input  wire                   sys_rst,
    input  wire                   spiEnable,
    input  wire                   masterMode,
    input  wire                   cpol,
    input  wire                   csPin_n,
    input  wire                   sckPin,
    input  wire                   mosiPin,
    output wire                   misoOut,
    output wire                   misoOe_n,
    input  wire                   masterFrameStart,
    input  wire                   masterFrameDone,
    input  wire [FRAME_W-1:0]     masterRxData,
    output wire [FRAME_W-1:0]     txShiftData,
    input  wire                   modeFaultEvent,
    input  wire                   dataWrite,
    input  wire [FRAME_W-1:0]     dataWriteData,
    input  wire                   dataRead,
    output wire [FRAME_W-1:0]     dataReadData,
    input  wire                   flagClearWrite,
    input  wire [`SEI_FLAG_W-1:0] flagClearData,
    input  wire [`SEI_FLAG_W-1:0] irqEnable,
    input  wire                   txDmaEnable,
    input  wire                   rxDmaEnable,
    output wire [`SEI_FLAG_W-1:0] statusFlags,
    output wire                   busy,
    output wire                   slaveSelected,
    output wire                   irqRequest,
    output wire                   txDmaRequest,
    output wire                   rxDmaRequest
);

    // Bit counter is wide enough to hold FRAME_W itself
    localparam CNT_W = $clog2(FRAME_W + 1);
    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam integer     LAST_BIT = FRAME_W - 1;
    localparam [CNT_W-1:0] CNT_LAST = LAST_BIT[CNT_W-1:0];

    // ----------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------
    wire [2:0] pinLvl;
    wire       csLvl;
    wire       sckLvl;
    wire       mosiLvl;

    sei_pin_sync #(
        .WIDTH (3)
    ) uPinSync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   ({mosiPin, sckPin, csPin_n}),
        .pinLvl  (pinLvl)
    );

    assign csLvl   = pinLvl[0];
    assign sckLvl  = pinLvl[1];
    assign mosiLvl = pinLvl[2];

    reg                   csPrev_reg;
    reg                   sckPrev_reg;
    reg [`SEI_FLAG_W-1:0] flags_reg;
    reg [`SEI_FLAG_W-1:0] flags_next;
    reg [FRAME_W-1:0]     txBuf_reg;
    reg [FRAME_W-1:0]     txShift_reg;
    reg [FRAME_W-1:0]     rxShift_reg;
    reg [FRAME_W-1:0]     rxData_reg;
    reg [CNT_W-1:0]       bitCnt_reg;
    reg                   loaded_reg;
    reg                   misoOe_n_reg;

    // Previous synchronised levels, reset to idle so no edge is seen
    // With cpol low the first level drop after reset looks like a trailing
    // edge; it is harmless because nothing shifts while deselected
    always @(posedge clk) begin
        if (sys_rst) begin
            csPrev_reg  <= `SEI_SYNC_RST;
            sckPrev_reg <= `SEI_SYNC_RST;
        end else begin
            csPrev_reg  <= csLvl;
            sckPrev_reg <= sckLvl;
        end
    end

    wire csFall   = csPrev_reg & ~csLvl;
    wire csRise   = ~csPrev_reg & csLvl;
    wire sckMove  = sckLvl ^ sckPrev_reg;
    wire sckLead  = sckMove & (sckLvl != cpol);
    wire sckTrail = sckMove & (sckLvl == cpol);

    // ----------------------------------------------------------------
    // Frame events
    // ----------------------------------------------------------------
    wire slaveMode   = spiEnable & ~masterMode;
    wire masterOn    = spiEnable & masterMode;
    wire slaveActive = slaveMode & ~csLvl;
    wire cntZero     = (bitCnt_reg == CNT_ZERO);
    wire txFull      = ~flags_reg[`SEI_TXE];

    // A select error only counts while bits of a frame have been taken
    wire slave_select_error_flag      = slaveMode & csRise & ~cntZero;
    wire slvStart   = slaveActive & sckLead & cntZero;
    wire slvDone    = slaveActive & sckLead & (bitCnt_reg == CNT_LAST);
    wire underflow  = slvStart & ~loaded_reg;
    // Loading is kept off the first edge so underflow and load never clash
    wire slvLoad    = slaveActive & cntZero & ~loaded_reg & txFull & ~sckLead;
    wire mstLoad    = masterOn & masterFrameStart & txFull;
    wire txLoad     = slvLoad | mstLoad;
    wire frameDone  = slvDone | (masterOn & masterFrameDone);
    wire [FRAME_W-1:0] slvWord = {rxShift_reg[FRAME_W-2:0], mosiLvl};
    wire [FRAME_W-1:0] rxWord  = masterMode ? masterRxData : slvWord;

    // ----------------------------------------------------------------
    // Slave bit counter and frame ownership
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            bitCnt_reg <= CNT_ZERO;
            loaded_reg <= 1'b0;
        end else if (!slaveActive || slave_select_error_flag) begin
            // Error or deselect abandons the frame: back to unselected
            bitCnt_reg <= CNT_ZERO;
            loaded_reg <= 1'b0;
        end else if (slvDone) begin
            bitCnt_reg <= CNT_ZERO;
            loaded_reg <= 1'b0;
        end else begin
            // Next select low starts cleanly from bit zero
            if (sckLead) begin
                bitCnt_reg <= bitCnt_reg + CNT_ONE;
            end
            if (slvLoad || slvStart) begin
                loaded_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Transmit path: buffer, shifter and MISO drive
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            txBuf_reg <= {FRAME_W{1'b0}};
        end else if (dataWrite) begin
            txBuf_reg <= dataWriteData;
        end
    end

    // Underflow sends zeros; the shifter is emptied after every slave frame so
    // that no leftover bit of an old word leads an unloaded frame
    always @(posedge clk) begin
        if (sys_rst) begin
            txShift_reg <= {FRAME_W{1'b0}};
        end else if (txLoad) begin
            txShift_reg <= txBuf_reg;
        end else if (underflow) begin
            txShift_reg <= {FRAME_W{1'b0}};
        end else if (slvDone || slave_select_error_flag) begin
            txShift_reg <= {FRAME_W{1'b0}};
        end else if (slaveActive && sckTrail && !cntZero) begin
            txShift_reg <= {txShift_reg[FRAME_W-2:0], 1'b0};
        end
    end

    // MISO is driven only while this slave is selected
    always @(posedge clk) begin
        if (sys_rst) begin
            misoOe_n_reg <= 1'b1;
        end else begin
            misoOe_n_reg <= ~slaveActive;
        end
    end

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            rxShift_reg <= {FRAME_W{1'b0}};
        end else if (slaveActive && sckLead) begin
            rxShift_reg <= slvWord;
        end
    end

    // New data always lands, unread data is simply lost
    always @(posedge clk) begin
        if (sys_rst) begin
            rxData_reg <= {FRAME_W{1'b0}};
        end else if (frameDone) begin
            rxData_reg <= rxWord;
        end
    end

    // ----------------------------------------------------------------
    // Status flags; every hardware set except transmit empty beats a same-cycle clear
    // ----------------------------------------------------------------
    wire [`SEI_FLAG_W-1:0] clrHits =
        (flagClearWrite ? ~flagClearData : {`SEI_FLAG_W{1'b0}}) & `SEI_CLR_MASK;

    always @* begin
        flags_next = flags_reg & ~clrHits;
        // Transmit empty: a data write wins, the buffer holds new data
        if (txLoad) begin
            flags_next[`SEI_TXE] = 1'b1;
        end
        if (dataWrite) begin
            flags_next[`SEI_TXE] = 1'b0;
        end
        if (dataRead) begin
            flags_next[`SEI_RX_NOT_EMPTY_FLAG] = 1'b0;
        end
        if (frameDone) begin
            flags_next[`SEI_RX_NOT_EMPTY_FLAG] = 1'b1;
        end
        if (frameDone && flags_reg[`SEI_RX_NOT_EMPTY_FLAG]) begin
            flags_next[`SEI_OV] = 1'b1;
        end
        if (underflow) begin
            flags_next[`SEI_UD] = 1'b1;
        end
        if (slave_select_error_flag) begin
            flags_next[`SEI_SLAVE_SELECT_ERROR_FLAG] = 1'b1;
        end
        if (slaveMode && csFall) begin
            flags_next[`SEI_SSF] = 1'b1;
        end
        if (slaveMode && csRise) begin
            flags_next[`SEI_SSR] = 1'b1;
        end
        if (modeFaultEvent) begin
            flags_next[`SEI_MODE_FAULT_FLAG] = 1'b1;
        end
    end

    // Flag register; reset leaves only the transmit-empty flag set
    always @(posedge clk) begin
        if (sys_rst) begin
            flags_reg <= `SEI_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ----------------------------------------------------------------
    // Requests toward interrupt and DMA controllers
    // ----------------------------------------------------------------
    // Requests are combinational levels of the flag register
    sei_req_gen uReqGen (
        .flags        (flags_reg),
        .irqEnable    (irqEnable),
        .txDmaEnable  (txDmaEnable),
        .rxDmaEnable  (rxDmaEnable),
        .irqRequest   (irqRequest),
        .txDmaRequest (txDmaRequest),
        .rxDmaRequest (rxDmaRequest)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // MISO shows the shifter MSB; misoOe_n decides whether it reaches the pin
    assign misoOut       = txShift_reg[FRAME_W-1];
    assign misoOe_n      = misoOe_n_reg;
    assign txShiftData   = txShift_reg;
    assign dataReadData  = rxData_reg;
    assign statusFlags   = flags_reg;
    // Busy lets software wait out the last slave frame before disabling; in master mode it only shows a full transmit buffer
    assign busy          = txFull | loaded_reg | ~cntZero;
    assign slaveSelected = slaveActive;

endmodule // sei_flag_core

// *** sei_flag_core_checker.sv ***
/* Assertions on the ports of sei_flag_core: flags, requests, sticky bits.
   Assumes one clock domain and the synchronous active-high reset. */
`timescale 1ns/1ps
`include "sei_regs.vh"

module sei_flag_core_checker #(
    parameter FRAME_W = 8
) (
    input wire logic                   clk,
    input wire logic                   sys_rst,
    input wire logic                   spiEnable,
    input wire logic                   masterMode,
    input wire logic                   masterFrameDone,
    input wire logic                   modeFaultEvent,
    input wire logic                   dataWrite,
    input wire logic                   dataRead,
    input wire logic                   flagClearWrite,
    input wire logic [`SEI_FLAG_W-1:0] flagClearData,
    input wire logic [`SEI_FLAG_W-1:0] irqEnable,
    input wire logic                   txDmaEnable,
    input wire logic                   rxDmaEnable,
    input wire logic [`SEI_FLAG_W-1:0] statusFlags,
    input wire logic                   irqRequest,
    input wire logic                   txDmaRequest,
    input wire logic                   rxDmaRequest
);
// ---------------------------------------------
// Properties
// ---------------------------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
wire mDone = masterMode && spiEnable && masterFrameDone;
// Requests are plain levels of the flag registers
irq_level_a: assert property (irqRequest == |(statusFlags & irqEnable))
    else $error("irq level wrong");
tx_dma_a: assert property (txDmaRequest == (txDmaEnable && statusFlags[0]))
    else $error("tx dma request wrong");
rx_dma_a: assert property (rxDmaRequest == (rxDmaEnable && statusFlags[1]))
    else $error("rx dma request wrong");
// Sticky bits survive anything but a clear write
ov_sticky_a: assert property (statusFlags[5] && !(flagClearWrite && !flagClearData[5]) |=> statusFlags[5])
    else $error("overflow lost");
ud_sticky_a: assert property (statusFlags[4] && !(flagClearWrite && !flagClearData[4]) |=> statusFlags[4])
    else $error("underflow lost");
slave_select_error_flag_sticky_a: assert property (statusFlags[6] && !(flagClearWrite && !flagClearData[6]) |=> statusFlags[6])
    else $error("select error lost");
mode_fault_flag_clear_a: assert property (flagClearWrite && !flagClearData[7] && !modeFaultEvent |=> !statusFlags[7])
    else $error("mode fault not cleared");
txe_clear_a: assert property (dataWrite |=> !statusFlags[0])
    else $error("write left buffer empty");
rx_not_empty_flag_set_a: assert property (mDone |=> statusFlags[1])
    else $error("frame not flagged");
ov_set_a: assert property (mDone && statusFlags[1] && !dataRead && !flagClearWrite |=> statusFlags[5])
    else $error("overflow missed");
endmodule // sei_flag_core_checker

bind sei_flag_core sei_flag_core_checker #(.FRAME_W(FRAME_W)) i_chk (.*);

// *** sei_spi_master_model.sv ***
/* Behavioural SPI master on the far side of the slave pins, mode 0, MSB first.
   Assumes the bench calls frame() just after a falling clk edge. */
`timescale 1ns/1ps

module sei_spi_master_model (
    output logic csPin_n,
    output logic sckPin,
    output logic mosiPin,
    input  wire  misoOut,
    input  wire  misoOe_n
);
initial begin
    csPin_n = 1'b1;
    sckPin  = 1'b0;
    mosiPin = 1'b0;
end
// One frame of n bits; 800 ns per phase so the slave's pin sync keeps up
task automatic frame(input int n, input logic [7:0] tx, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    csPin_n = 1'b0;
    #1000;
    for (i = 0; i < n; i++) begin
        mosiPin = tx[7-i];
        #800 sckPin = 1'b1;
        // A released line reads as the inverse of the last bit shown
        rx = {rx[6:0], misoOe_n ? ~misoOut : misoOut};
        #800 sckPin = 1'b0;
    end
    #800 csPin_n = 1'b1;
    mosiPin = ~mosiPin; // Released line shows no stale bit
endtask
endmodule // sei_spi_master_model

// *** sei_flag_core_tb.sv ***
/* Self-checking bench for sei_flag_core: slave frames, errors, clears, master frames.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps

module sei_flag_core_tb;
logic clk = 0, sys_rst = 1, spiEnable = 1, masterMode = 0, cpol = 0, masterFrameStart = 0, masterFrameDone = 0;
logic modeFaultEvent = 0, dataWrite = 0, dataRead = 0, flagClearWrite = 0, txDmaEnable = 1, rxDmaEnable = 1;
logic [7:0] masterRxData = 0, dataWriteData = 0, flagClearData = 8'hFF, irqEnable = 0, expF, g, d, m;
wire [7:0] txShiftData, dataReadData, statusFlags;
wire csPin_n, sckPin, mosiPin, misoOut, misoOe_n, busy, slaveSelected, irqRequest, txDmaRequest, rxDmaRequest;
int n_fail = 0, checked = 0, b;
logic [7:0] rxQ[$]; // Words the far side sent, newest last
sei_flag_core i_dut (.*);
sei_spi_master_model i_master (.csPin_n(csPin_n), .sckPin(sckPin), .mosiPin(mosiPin), .misoOut(misoOut),
    .misoOe_n(misoOe_n));
initial forever #50 clk = ~clk;
initial begin
    #400000 n_fail++;
    stop_test;
end
// ---------------------------------------------
// Compare and drive helpers
// ---------------------------------------------
task automatic cmp8(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
        n_fail++;
        $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
endtask
task automatic cmp1(input logic got, exp);
    checked++;
    if (got !== exp) begin
        n_fail++;
        $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
endtask
// Flags and the three request levels against the bench's own flag model
task automatic flagsOk;
    @(negedge clk);
    cmp8(statusFlags, expF);
    cmp1(irqRequest, |(expF & irqEnable));
    cmp1(txDmaRequest, txDmaEnable & expF[0]);
    cmp1(rxDmaRequest, rxDmaEnable & expF[1]);
    cmp1(busy, ~expF[0]);
    cmp1(slaveSelected, 1'b0);
    cmp1(misoOe_n, 1'b1);
endtask
task automatic pulse(ref logic s);
    @(negedge clk) s = 1;
    @(negedge clk) s = 0;
endtask
task automatic slv(input int n, input logic [7:0] tx, exp);
    fork
        i_master.frame(n, tx, g);
        begin
            // Select is settled and MISO driven well before the first clock edge
            repeat (14) @(negedge clk);
            cmp1(slaveSelected, 1'b1);
            cmp1(misoOe_n, 1'b0);
        end
    join
    if (n == 8) rxQ.push_back(tx);
    repeat (8) @(negedge clk);
    cmp8(g, exp);
endtask
task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
// ---------------------------------------------
// Main sequence
// ---------------------------------------------
initial begin
    b = $urandom(32'h358C);
    repeat (2) @(negedge clk);
    sys_rst = 0;
    irqEnable = $urandom;
    expF = 8'h01;
    flagsOk;
    d = $urandom;
    dataWriteData = d;
    pulse(dataWrite);
    expF[0] = 0;
    flagsOk;
    m = $urandom;
    slv(8, m, d);
    expF = expF | 8'h0F;
    flagsOk;
    cmp8(dataReadData, rxQ[$]);
    m = $urandom;
    slv(8, m, 8'h00);
    expF = expF | 8'h30;
    flagsOk;
    cmp8(dataReadData, rxQ[$]);
    pulse(dataRead);
    expF[1] = 0;
    flagsOk;
    slv(3, $urandom, 8'h00);
    expF[6] = 1;
    flagsOk;
    m = $urandom;
    slv(8, m, 8'h00);
    expF[1] = 1;
    flagsOk;
    cmp8(dataReadData, rxQ[$]);
    pulse(modeFaultEvent);
    expF[7] = 1;
    flagsOk;
    // Handler style: clear one flag at a time, enables reshuffled each pass
    for (b = 1; b < 8; b++) begin
        @(negedge clk) irqEnable = $urandom;
        {txDmaEnable, rxDmaEnable} = $urandom;
        flagClearData = ~(8'h01 << b);
        pulse(flagClearWrite);
        expF[b] = 0;
        flagsOk;
    end
    flagClearData = 8'hFF;
    masterMode = 1;
    // Two master frames back to back without a read: second one overflows
    for (b = 0; b < 2; b++) begin
        d = $urandom;
        dataWriteData = d;
        pulse(dataWrite);
        pulse(masterFrameStart);
        cmp8(txShiftData, d);
        masterRxData = $urandom;
        rxQ.push_back(masterRxData);
        pulse(masterFrameDone);
        expF[5] = expF[5] | expF[1];
        expF[1] = 1;
        expF[0] = 1;
        flagsOk;
        cmp8(dataReadData, rxQ[$]);
    end
    // Software empties the receive side and checks for idle before switching off
    pulse(dataRead);
    expF[1] = 0;
    cmp1(busy, 1'b0);
    spiEnable = 0;
    pulse(masterFrameDone);
    flagsOk;
    stop_test;
end
endmodule // sei_flag_core_tb
